//--- core/nifb_frame_builder.sv
/*
 * Node identification frame builder: captures one received identification
 * broadcast, serialises the indicator frame byte by byte toward the host
 * port, flashes the association indicator, and raises the node's own
 * identification request on a button press, a commissioning write or a
 * long synchronous-sleep wait.
 * Assumes rx_* and tx_ready come from logic on clk; button is a raw pin.
 * Assumes the host paces the byte stream only through tx_ready.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
// Operation
// - One indicator frame per received identification broadcast with a valid delivery method; one arriving while rx_ready is low is dropped.
// - Own identification on single button press or commissioning write of 1.
// - Own identification after 30 s awake waiting for sync.
// - Start delimiter byte at offset 0.
// - Length at offset 1 counts bytes between length and checksum.
// - Frame type 0x95 at offset 3, source address at offset 4.
// - Reserved fields at 12, 15 and after name carry 0xfffe.
// - Options at 14, bit 1 marks broadcast, reserved bits zero.
// - Options bits 7:6 carry delivery method; code 00 invalid.
// - Remote originator address at offset 17.
// - Null-terminated name from offset 25, two bytes minimum.
// - Network role byte follows the reserved field after name.
// - Source event byte follows the role byte.
// - Fixed profile and maker codes follow the event byte.
// - Device type tag present only when its discovery bit set.
// - Signal strength byte before checksum only when its bit set.
// - Checksum is 0xff minus byte sum from offset 3.
// - Association indicator flashes on each received broadcast with a valid delivery method.
module nifb_frame_builder
    import nifb_pkg::*;
#(
    parameter longint unsigned SYNC_WAIT = SYNC_WAIT_CYCLES,
    parameter longint unsigned LED_FLASH = LED_FLASH_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Received identification broadcast
    input wire logic rx_valid,
    input wire nifb_rx_type rx_info,
    output logic rx_ready,
    // Byte stream to host serial port
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_last,
    // Local identification sources
    input wire logic button,
    input wire logic sync_waiting,
    output logic ident_req,
    // Association indicator
    output logic assoc_led
);

    nifb_state_type state_r;
    nifb_rx_type cap_r;
    logic [7:0] name_r [NAME_MAX];
    logic [6:0] name_bytes_r;
    logic [6:0] idx_r;
    logic [6:0] last_idx_r;
    logic [15:0] len_r;
    logic [7:0] sum_r;
    logic [1:0] disc_opt_r;
    logic [15:0] sent_cnt_r;
    logic [7:0] drop_cnt_r;
    logic [1:0] btn_sync_r;
    logic btn_prev_r;
    logic [31:0] wait_cnt_r;
    logic wait_done_r;
    logic [31:0] led_cnt_r;
    logic [7:0] cur_byte;
    logic [6:0] tail_rel;
    logic [6:0] name_rel;
    logic load_ok;
    logic take_rx;
    logic [6:0] nb_nxt;
    logic [6:0] opt_len;

    // Output register accepts a new byte whenever it is empty or drained
    assign load_ok = !tx_valid || tx_ready;
    assign take_rx = rx_valid && rx_ready && (rx_info.method != METHOD_INVALID);

    // Terminated name bytes; empty names padded so the field is two bytes
    assign nb_nxt = (rx_info.name_len == 5'h00) ? 7'h02 : {2'h0, rx_info.name_len} + 7'h01;
    assign opt_len = (disc_opt_r[DISC_TAG_BIT] ? 7'h04 : 7'h00)
        + (disc_opt_r[DISC_RSSI_BIT] ? 7'h01 : 7'h00);

    // Frame byte selection from position
    assign name_rel = idx_r - OFS_NAME;
    assign tail_rel = idx_r - OFS_NAME - name_bytes_r;

    always_comb
    begin
        cur_byte = 8'h00;
        if (idx_r == last_idx_r)
            cur_byte = CKSUM_BASE - sum_r;
        else if (idx_r < OFS_NAME)
        begin
            unique case (idx_r)
                OFS_DELIM: cur_byte = START_DELIM;
                OFS_LEN: cur_byte = len_r[15:8];
                OFS_LEN + 7'h01: cur_byte = len_r[7:0];
                OFS_TYPE: cur_byte = FRAME_TYPE_NODE_ID;
                OFS_RES0, OFS_RES1: cur_byte = RESERVED_FILL[15:8];
                OFS_RES0 + 7'h01, OFS_RES1 + 7'h01: cur_byte = RESERVED_FILL[7:0];
                OFS_OPT: cur_byte = {cap_r.method, 6'h00}
                    | (cap_r.bcast ? OPT_BCAST : 8'h00);
                default:
                begin
                    if (idx_r >= OFS_REMOTE)
                        cur_byte = cap_r.remote_addr[8'(7'h07 - (idx_r - OFS_REMOTE)) * 8 +: 8];
                    else
                        cur_byte = cap_r.src_addr[8'(7'h07 - (idx_r - OFS_SRC)) * 8 +: 8];
                end
            endcase
        end
        else if (name_rel < name_bytes_r)
        begin
            if (name_rel == name_bytes_r - 7'h01)
                cur_byte = NAME_TERM;
            else if (cap_r.name_len == 5'h00)
                cur_byte = NAME_PAD;
            else
                cur_byte = name_r[name_rel[4:0]];
        end
        else
        begin
            unique case (tail_rel)
                7'h00: cur_byte = RESERVED_FILL[15:8];
                7'h01: cur_byte = RESERVED_FILL[7:0];
                7'h02: cur_byte = cap_r.role;
                7'h03: cur_byte = cap_r.event_code;
                7'h04: cur_byte = PROFILE_CODE[15:8];
                7'h05: cur_byte = PROFILE_CODE[7:0];
                7'h06: cur_byte = MAKER_CODE[15:8];
                7'h07: cur_byte = MAKER_CODE[7:0];
                default:
                begin
                    // Tag first, then signal strength
                    if (disc_opt_r[DISC_TAG_BIT] && tail_rel < TAIL_FIXED + 7'h04)
                        cur_byte = cap_r.dev_tag[8'(7'h03 - (tail_rel - TAIL_FIXED)) * 8 +: 8];
                    else
                        cur_byte = cap_r.rssi;
                end
            endcase
        end
    end

    // Frame sequencer; capture only while idle, busy refuses via rx_ready
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            idx_r <= 7'h00;
            last_idx_r <= 7'h00;
            len_r <= 16'h0000;
            name_bytes_r <= 7'h02;
            cap_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (take_rx)
                    begin
                        cap_r <= rx_info;
                        name_bytes_r <= nb_nxt;
                        len_r <= {9'h000, LEN_FIXED + nb_nxt + opt_len};
                        last_idx_r <= OFS_NAME + nb_nxt + TAIL_FIXED + opt_len;
                        idx_r <= 7'h00;
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (load_ok)
                    begin
                        idx_r <= idx_r + 7'h01;
                        if (idx_r == last_idx_r)
                            state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Name storage, indexed flip-flops
    generate
        for (genvar i = 0; i < NAME_MAX; i++)
        begin : g_name
            always_ff @(posedge clk)
            begin
                if (reset)
                    name_r[i] <= 8'h00;
                else if (take_rx && state_r == ST_IDLE)
                    name_r[i] <= rx_info.name[NAME_MAX - 1 - i];
            end
        end
    endgenerate

    // Running checksum over bytes from the frame type onward
    always_ff @(posedge clk)
    begin
        if (reset || state_r == ST_IDLE)
            sum_r <= 8'h00;
        else if (load_ok && idx_r >= CKSUM_FROM && idx_r != last_idx_r)
            sum_r <= sum_r + cur_byte;
    end

    // Output byte register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end
        else if (load_ok)
        begin
            tx_valid <= (state_r == ST_SEND);
            tx_data <= cur_byte;
            tx_last <= (state_r == ST_SEND) && (idx_r == last_idx_r);
        end
    end

    // Ready only in idle; next frame may start once the last byte is loaded
    always_ff @(posedge clk)
    begin
        if (reset)
            rx_ready <= 1'b0;
        else
            rx_ready <= (state_r == ST_IDLE) && !take_rx
                && !(state_r == ST_SEND && load_ok && idx_r != last_idx_r);
    end

    // Counters: frames built and broadcasts dropped
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sent_cnt_r <= 16'h0000;
            drop_cnt_r <= 8'h00;
        end
        else
        begin
            if (state_r == ST_SEND && load_ok && idx_r == last_idx_r)
                sent_cnt_r <= sent_cnt_r + 16'h0001;
            if (rx_valid && !take_rx && drop_cnt_r != 8'hff)
                drop_cnt_r <= drop_cnt_r + 8'h01; // Saturates, no wrap
        end
    end

    // Indicator flash, retriggered by every valid broadcast
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            led_cnt_r <= 32'h0000_0000;
            assoc_led <= 1'b0;
        end
        else
        begin
            if (rx_valid && rx_info.method != METHOD_INVALID)
                led_cnt_r <= 32'(LED_FLASH);
            else if (led_cnt_r != 32'h0000_0000)
                led_cnt_r <= led_cnt_r - 32'h0000_0001;
            assoc_led <= (led_cnt_r != 32'h0000_0000);
        end
    end

    // Button pin synchroniser and press edge
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            btn_sync_r <= 2'h0;
            btn_prev_r <= 1'b0;
        end
        else
        begin
            btn_sync_r <= {btn_sync_r[0], button};
            btn_prev_r <= btn_sync_r[1];
        end
    end

    // Sync-sleep wait timer fires once per awake period
    always_ff @(posedge clk)
    begin
        if (reset || !sync_waiting)
        begin
            wait_cnt_r <= 32'h0000_0000;
            wait_done_r <= 1'b0;
        end
        else if (!wait_done_r)
        begin
            if (wait_cnt_r == 32'(SYNC_WAIT) - 32'h0000_0001)
                wait_done_r <= 1'b1;
            wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
        end
    end

    // Own identification request, one-cycle pulse
    always_ff @(posedge clk)
    begin
        if (reset)
            ident_req <= 1'b0;
        else
            ident_req <= (btn_sync_r[1] && !btn_prev_r)
                || (reg_wr && reg_addr == REG_COMMISSION
                    && reg_wdata[7:0] == COMMISSION_IDENT)
                || (sync_waiting && !wait_done_r
                    && wait_cnt_r == 32'(SYNC_WAIT) - 32'h0000_0001);
    end

    // Register writes
    always_ff @(posedge clk)
    begin
        if (reset)
            disc_opt_r <= DISC_OPT_RESET;
        else if (reg_wr && reg_addr == REG_DISC_OPT)
            disc_opt_r <= reg_wdata[1:0];
    end

    // Register reads, data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (reset || !reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            unique case (reg_addr)
                REG_DISC_OPT: reg_rdata <= {30'h0000_0000, disc_opt_r};
                REG_STATUS: reg_rdata <= {7'h00, (state_r == ST_SEND), drop_cnt_r, sent_cnt_r};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : nifb_frame_builder

//--- core/nifb_pkg.sv
/*
 * Package of the node identification frame builder: field offsets,
 * frame constants, register map, timing counts and the carrier struct.
 * Assumes a single 50 MHz system clock shared by all users.
 */
package nifb_pkg;

    // Clock and timing
    localparam longint unsigned CLK_HZ = 64'd50_000_000;
    localparam longint unsigned SYNC_WAIT_S = 64'd30;
    localparam longint unsigned SYNC_WAIT_CYCLES = SYNC_WAIT_S * CLK_HZ;
    localparam longint unsigned LED_FLASH_MS = 64'd250;
    localparam longint unsigned LED_FLASH_CYCLES = (LED_FLASH_MS * CLK_HZ) / 64'd1000;

    // Frame constants
    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] FRAME_TYPE_NODE_ID = 8'h95;
    localparam logic [15:0] RESERVED_FILL = 16'hfffe;
    localparam logic [7:0] NAME_TERM = 8'h00;
    localparam logic [7:0] NAME_PAD = 8'h20;
    localparam logic [7:0] CKSUM_BASE = 8'hff;
    localparam logic [7:0] OPT_BCAST = 8'h02;
    localparam int OPT_METHOD_LSB = 6;
    localparam logic [7:0] EVENT_BUTTON = 8'h01;
    // Profile and maker codes: arbitrary neutral values
    localparam logic [15:0] PROFILE_CODE = 16'h1234;
    localparam logic [15:0] MAKER_CODE = 16'h5678;

    // Fixed byte offsets and counts
    localparam logic [6:0] OFS_DELIM = 7'h00;
    localparam logic [6:0] OFS_LEN = 7'h01;
    localparam logic [6:0] OFS_TYPE = 7'h03;
    localparam logic [6:0] OFS_SRC = 7'h04;
    localparam logic [6:0] OFS_RES0 = 7'h0c;
    localparam logic [6:0] OFS_OPT = 7'h0e;
    localparam logic [6:0] OFS_RES1 = 7'h0f;
    localparam logic [6:0] OFS_REMOTE = 7'h11;
    localparam logic [6:0] OFS_NAME = 7'h19;
    localparam logic [6:0] CKSUM_FROM = 7'h03;
    localparam logic [6:0] TAIL_FIXED = 7'h08;
    localparam logic [6:0] LEN_FIXED = 7'h1e;

    // Name string storage, characters without terminator
    localparam int NAME_MAX = 20;

    // Register map (byte addresses)
    localparam logic [7:0] REG_DISC_OPT = 8'h00;
    localparam logic [7:0] REG_COMMISSION = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int DISC_TAG_BIT = 0;
    localparam int DISC_RSSI_BIT = 1;
    localparam logic [1:0] DISC_OPT_RESET = 2'h0;
    localparam logic [7:0] COMMISSION_IDENT = 8'h01;

    // Delivery method codes
    localparam logic [1:0] METHOD_INVALID = 2'h0;

    // One received identification broadcast
    typedef struct packed {
        logic [63:0] src_addr;
        logic [63:0] remote_addr;
        logic bcast;
        logic [1:0] method;
        logic [NAME_MAX-1:0][7:0] name;
        logic [4:0] name_len;
        logic [7:0] role;
        logic [7:0] event_code;
        logic [31:0] dev_tag;
        logic [7:0] rssi;
    } nifb_rx_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } nifb_state_type;

endpackage : nifb_pkg

//--- test/nifb_frame_builder_sva.sv
/* Checker for the node identification frame builder ports.
   Assumes one clock and the builder's own parameter values. */
module nifb_frame_builder_sva
    import nifb_pkg::*;
#(
    parameter longint unsigned SYNC_WAIT = SYNC_WAIT_CYCLES,
    parameter longint unsigned LED_FLASH = LED_FLASH_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Received broadcast
    input wire logic rx_valid,
    input wire nifb_rx_type rx_info,
    input wire logic rx_ready,
    // Host stream
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_last,
    // Local sources and indicator
    input wire logic button,
    input wire logic sync_waiting,
    input wire logic ident_req,
    input wire logic assoc_led
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic take;
    logic [63:0] led_run_r;

    // Accepted broadcast with a usable delivery method
    assign take = rx_valid && rx_ready && (rx_info.method != METHOD_INVALID);

    // Length of the current flash; a new broadcast restarts it
    always_ff @(posedge clk)
    begin
        if (reset || (rx_valid && rx_info.method != METHOD_INVALID) || !assoc_led)
            led_run_r <= '0;
        else
            led_run_r <= led_run_r + 64'h1;
    end

    frame_start_a: assert property (take |-> ##[1:3] (tx_valid && tx_data == START_DELIM))
        else $error("no start byte after accepted broadcast");
    delim_first_a: assert property ($rose(tx_valid) |-> tx_data == START_DELIM)
        else $error("frame opens with wrong byte");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed before acceptance");
    one_frame_a: assert property (tx_valid && !tx_last |-> !rx_ready)
        else $error("ready while frame in flight");
    invalid_method_a: assert property (
        rx_valid && rx_ready && !tx_valid && rx_info.method == METHOD_INVALID
        |=> !tx_valid [*3]) else $error("frame for invalid method");
    commission_pulse_a: assert property (reg_wr && reg_addr == REG_COMMISSION
        && reg_wdata[7:0] == COMMISSION_IDENT |=> ident_req) else $error("no ident pulse");
    button_ident_a: assert property ($rose(button) |-> ##[2:4] ident_req)
        else $error("no ident after button");
    ident_single_a: assert property (ident_req |=> !ident_req)
        else $error("ident pulse too long");
    led_on_a: assert property (take |-> ##[1:2] assoc_led)
        else $error("indicator not lit");
    led_length_a: assert property (led_run_r <= LED_FLASH)
        else $error("indicator lit too long");
endmodule : nifb_frame_builder_sva

bind nifb_frame_builder nifb_frame_builder_sva #(.SYNC_WAIT(SYNC_WAIT), .LED_FLASH(LED_FLASH))
    u_sva (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid,
    .rx_info, .rx_ready, .tx_data, .tx_valid, .tx_ready, .tx_last, .button, .sync_waiting,
    .ident_req, .assoc_led);

//--- test/nifb_host_sink.sv
/* Host processor model: accepts the builder's byte stream.
   Assumes the stream runs on the bench clock. */
module nifb_host_sink
    import nifb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pacing control from the bench
    input wire logic slow,
    // Byte stream
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    int frames;

    // A slow host stalls every other cycle, so held bytes get exercised
    always_ff @(posedge clk)
    begin
        if (reset)
            tx_ready <= 1'b0;
        else
            tx_ready <= slow ? !tx_ready : 1'b1;
    end

    // Keep every accepted byte and count whole frames
    always @(posedge clk)
    begin
        if (!reset && tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
            if (tx_last)
                frames++;
        end
    end
endmodule : nifb_host_sink

//--- test/node_ident_frame_builder_tb.sv
/* Testbench of the node identification frame builder.
   Assumes the host sink model and the bound checker. */
module node_ident_frame_builder_tb
    import nifb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened counts keep the run brief
    localparam longint unsigned SYNC_W = 64'd20;
    localparam longint unsigned LED_F = 64'd8;
    logic clk;
    logic reset;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic rx_valid;
    nifb_rx_type rx_info;
    logic rx_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic tx_last;
    logic button;
    logic sync_waiting;
    logic ident_req;
    logic assoc_led;
    logic slow;
    int mismatches;
    int checked;

    nifb_frame_builder #(.SYNC_WAIT(SYNC_W), .LED_FLASH(LED_F)) dut (.clk, .reset, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_info, .rx_ready, .tx_data,
        .tx_valid, .tx_ready, .tx_last, .button, .sync_waiting, .ident_req, .assoc_led);
    nifb_host_sink sink (.clk, .reset, .slow, .tx_data, .tx_valid, .tx_last, .tx_ready);

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // One register access; returns at the cycle where read data stand
    task automatic reg_io(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask : reg_io

    // Count ident pulses, starting in the current cycle
    task automatic pulses(int n, output int c);
        c = 0;
        repeat (n)
        begin
            c += ident_req;
            @(negedge clk);
        end
    endtask : pulses

    function automatic void put(ref logic [7:0] q[$], input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            q.push_back(v[i*8 +: 8]);
    endfunction : put

    // Expected frame, big-endian fields
    function automatic void build(nifb_rx_type r, logic [1:0] opt, ref logic [7:0] q[$]);
        logic [7:0] s;
        logic [15:0] len;
        q = {START_DELIM, 8'h00, 8'h00};
        put(q, 64'h95, 1);
        put(q, r.src_addr, 8);
        put(q, 64'hfffe, 2);
        put(q, {r.method, 4'h0, r.bcast, 1'b0}, 1);
        put(q, 64'hfffe, 2);
        put(q, r.remote_addr, 8);
        if (r.name_len == 5'h00)
            put(q, NAME_PAD, 1);
        for (int i = 0; i < r.name_len; i++)
            put(q, r.name[NAME_MAX - 1 - i], 1);
        put(q, 64'h00, 1);
        put(q, 64'hfffe, 2);
        put(q, r.role, 1);
        put(q, r.event_code, 1);
        put(q, PROFILE_CODE, 2);
        put(q, MAKER_CODE, 2);
        if (opt[DISC_TAG_BIT])
            put(q, r.dev_tag, 4);
        if (opt[DISC_RSSI_BIT])
            put(q, r.rssi, 1);
        len = 16'(q.size() - 3);
        q[1] = len[15:8];
        q[2] = len[7:0];
        s = 8'h00;
        for (int i = 3; i < q.size(); i++)
            s += q[i];
        put(q, 8'hff - s, 1);
    endfunction : build

    // Offer one broadcast, collect the frame and the flash length
    task automatic run_frame(nifb_rx_type r, logic [1:0] opt, logic pace);
        logic [7:0] exp[$];
        logic [7:0] got[$];
        logic [31:0] q;
        int n0;
        int f0;
        int led;
        int w;
        build(r, opt, exp);
        reg_io(1'b1, REG_DISC_OPT, {30'h0, opt}, q);
        n0 = sink.got.size();
        f0 = sink.frames;
        w = 0;
        while (rx_ready !== 1'b1 && w < 99)
        begin
            @(negedge clk);
            w++;
        end
        check("rx ready", rx_ready, 1'b1);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_info <= r;
        slow <= pace;
        @(posedge clk);
        rx_valid <= 1'b0;
        led = 0;
        while (sink.frames == f0 && w < 999)
        begin
            @(negedge clk);
            led += assoc_led;
            w++;
        end
        check("frame done", w < 999, 1'b1);
        got = sink.got[n0:$];
        check("len", got.size(), exp.size());
        check("delim", got[0], START_DELIM);
        check("opt", got[14], exp[14]);
        check("cksum", got[$], exp[$]);
        foreach (exp[i])
            check("b", got[i], exp[i]);
        check("flash", led, LED_F);
    endtask : run_frame

    // All methods and option pairs, names of 4, 0, 20 and 2 characters
    task automatic test_frames();
        nifb_rx_type r;
        int lens[4] = '{4, 0, 20, 2};
        for (int i = 0; i < 4; i++)
        begin
            r = '0;
            r.src_addr = 64'h0011_2233_4455_6600 + 64'(i);
            r.remote_addr = 64'h8899_aabb_ccdd_ee00 + 64'(i);
            r.bcast = i[0];
            r.method = 2'(i % 3 + 1);
            r.name_len = 5'(lens[i]);
            for (int k = 0; k < NAME_MAX; k++)
                r.name[NAME_MAX - 1 - k] = 8'h41 + 8'(k);
            r.role = 8'(i % 3);
            r.event_code = EVENT_BUTTON;
            r.dev_tag = 32'h1234_5600 + 32'(i);
            r.rssi = 8'h30 + 8'(i);
            run_frame(r, 2'(i), i[0]);
        end
    endtask : test_frames

    // Invalid method is dropped silently and counted
    task automatic test_drop();
        logic [31:0] s0;
        logic [31:0] s1;
        int n0;
        int led;
        reg_io(1'b0, REG_STATUS, 32'h0, s0);
        n0 = sink.got.size();
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_info.method <= METHOD_INVALID;
        @(posedge clk);
        rx_valid <= 1'b0;
        led = 0;
        repeat (12)
        begin
            @(negedge clk);
            led += assoc_led;
        end
        check("drop bytes", sink.got.size(), n0);
        check("drop flash", led, 0);
        reg_io(1'b0, REG_STATUS, 32'h0, s1);
        check("drop count", s1[23:16], s0[23:16] + 8'h1);
        check("frames sent", s0[15:0], 16'h4);
        check("busy idle", s0[31:24], 8'h00);
    endtask : test_drop

    // Register map, unmapped read and commissioning command
    task automatic test_regs();
        logic [31:0] q;
        int c;
        reg_io(1'b0, REG_DISC_OPT, 32'h0, q);
        check("opt reset", q, {30'h0, DISC_OPT_RESET});
        reg_io(1'b1, REG_DISC_OPT, 32'h3, q);
        reg_io(1'b0, REG_DISC_OPT, 32'h0, q);
        check("opt rw", q, 32'h3);
        reg_io(1'b0, 8'h0c, 32'h0, q);
        check("unmapped", q, 32'h0);
        reg_io(1'b1, REG_COMMISSION, {24'h0, COMMISSION_IDENT}, q);
        pulses(4, c);
        check("commission", c, 1);
        reg_io(1'b1, REG_COMMISSION, 32'h2, q);
        pulses(4, c);
        check("commission two", c, 0);
    endtask : test_regs

    // Button press and synchronous-sleep wait, with rearm
    task automatic test_local();
        int c;
        @(posedge clk);
        button <= 1'b1;
        @(negedge clk);
        pulses(8, c);
        check("button", c, 1);
        @(posedge clk);
        button <= 1'b0;
        sync_waiting <= 1'b1;
        @(negedge clk);
        pulses(50, c);
        check("sync wait", c, 1);
        @(posedge clk);
        sync_waiting <= 1'b0;
        @(posedge clk);
        sync_waiting <= 1'b1;
        @(negedge clk);
        pulses(12, c);
        check("sync short", c, 0);
        pulses(20, c);
        check("sync rearm", c, 1);
    endtask : test_local

    // Main sequence
    initial
    begin
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, rx_valid} = '0;
        {button, sync_waiting, slow} = '0;
        rx_info = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        test_regs();
        test_frames();
        test_drop();
        test_local();
        print_verdict();
    end

    // Watchdog far beyond the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : node_ident_frame_builder_tb
